//--- svo_pkg.sv
// servo axis gating package: register map, field layout, reset values, types
// assumes one 125 MHz clock domain and an apb master with 32-bit data
//
// Overview of operation
// - mode 0 regulates speed from the analog speed command sample.
// - mode 1 moves by command pulse count; pulse rate sets speed.
// - mode 2 regulates torque from the analog torque command sample.
// - mode 3 picks one of three stored speeds via three select inputs.
// - servo enable input low energizes the motor and permits motion.
// - servo enable input high keeps motor de-energized and inoperable.
// - default enable source is terminal one on axis A, five on axis B.
// - enable source 9 treats servo enable as always asserted from power-up.
// - with enable forced, alarm clear by command is ignored; restart clears.
// - parameter changes apply only at the next startup.
// - direction reversal flips the motor only, not encoder or monitor outputs.
// - standard direction: positive command turns counterclockwise from load side.
// - positive limit guards ccw with direction 0, cw with direction 1.
// - a released limit input forces the moving axis to stop.
// - positive limit low allows, high prohibits positive motion.
// - negative limit low allows, high prohibits negative motion.
// - during overtravel on one side, opposite-side motion is still accepted.
// - clear input zeroes the position error counter after an overtravel stop.
// - limit source 9 disables that side's overtravel check.
package svo_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_PARAM   = 8'h00;  // stored parameters, rw
  localparam logic [7:0] ADDR_ACTIVE  = 8'h04;  // parameters in force, ro
  localparam logic [7:0] ADDR_PRESET1 = 8'h08;  // internal speed 1, rw
  localparam logic [7:0] ADDR_PRESET2 = 8'h0c;
  localparam logic [7:0] ADDR_PRESET3 = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;  // ro
  localparam logic [7:0] ADDR_CONTROL = 8'h18;  // wo: restart / alarm clear

  // ****************************************************************
  // field positions and codes
  // ****************************************************************
  localparam int          MODE_LSB     = 4;
  localparam int          SON_LSB      = 8;
  localparam int          FWD_LSB      = 12;
  localparam int          REV_LSB      = 16;
  localparam int          DIR_BIT      = 0;
  localparam int          CTL_RESTART  = 0;
  localparam int          CTL_ALMCLR   = 1;
  localparam logic [3:0]  SRC_FORCED   = 4'h9;
  localparam logic [3:0]  SON_DEF_A    = 4'h1;
  localparam logic [3:0]  SON_DEF_B    = 4'h5;
  localparam logic [3:0]  FWD_DEF_A    = 4'h3;
  localparam logic [3:0]  FWD_DEF_B    = 4'h7;
  localparam logic [3:0]  REV_DEF_A    = 4'h4;
  localparam logic [3:0]  REV_DEF_B    = 4'h8;
  localparam int          NUM_TERMS    = 8;
  localparam int          SYNC_W       = 14;   // terms, clear, 3 selects, pulse, sign

  typedef enum logic [3:0] {
    SVO_MODE_SPEED  = 4'h0,
    SVO_MODE_PULSE  = 4'h1,
    SVO_MODE_TORQUE = 4'h2,
    SVO_MODE_PRESET = 4'h3
  } svo_mode_e;

  typedef struct packed {
    logic       dirRev;
    logic [3:0] revSrc;
    logic [3:0] fwdSrc;
    logic [3:0] sonSrc;
    svo_mode_e  mode;
  } svo_cfg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } svo_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } svo_apb_rsp_s;

  // reset value of the stored parameters, chosen per axis
  function automatic svo_cfg_s svo_cfg_default(input logic axisB);
    svo_cfg_s c;
    c.dirRev = 1'b0;
    c.mode   = SVO_MODE_SPEED;
    c.sonSrc = axisB ? SON_DEF_B : SON_DEF_A;
    c.fwdSrc = axisB ? FWD_DEF_B : FWD_DEF_A;
    c.revSrc = axisB ? REV_DEF_B : REV_DEF_A;
    return c;
  endfunction : svo_cfg_default

endpackage : svo_pkg

//--- svo_axis_ctrl.sv
// servo axis control: mode select, servo enable, direction, overtravel gating
// assumes input terminals are active low, clear and speed selects active high, and apb software access
`timescale 1ns/100ps
module svo_axis_ctrl #(
  parameter logic AXIS_B = 1'b0
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // apb slave
  input  wire svo_pkg::svo_apb_req_s  apbReq,
  output svo_pkg::svo_apb_rsp_s       apbRsp,
  // discrete inputs, terminals 1..8 on bits 0..7
  input  wire logic [7:0]             inputTerms_n,
  input  wire logic                   errorCounterClear,
  input  wire logic                   presetSpeedSelA,
  input  wire logic                   presetSpeedSelB,
  input  wire logic                   presetSpeedSelC,
  // command pulse train and analog command samples
  input  wire logic                   cmdPulse,
  input  wire logic                   cmdPulseNeg,
  input  wire logic signed [15:0]     speedRef,
  input  wire logic signed [15:0]     torqueRef,
  input  wire logic                   alarmEvent,
  input  wire logic                   encPulseIn,
  // drive outputs
  output logic                        motorEnergized,
  output svo_pkg::svo_mode_e          loopMode,
  output logic signed [15:0]          driveCmd,
  output logic                        encPulseOut,
  output logic                        alarm
);
  import svo_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [SYNC_W-1:0]  sync1;
    logic [SYNC_W-1:0]  sync2;
    logic               pulsePrev;
    svo_cfg_s           pend;
    svo_cfg_s           act;
    logic               loaded;
    logic [2:0][15:0]   preset;
    logic signed [15:0] errCnt;
    logic signed [15:0] drive;
    logic               energized;
    logic               fwdBlock;
    logic               revBlock;
    logic               alarm;
    logic               encOut;
    logic [31:0]        rdata;
    logic               slverr;
  } svo_state_s;

  svo_state_s st;
  svo_state_s next_st;

  // routed terminal level; source 9 reads as asserted (low)
  function automatic logic termLevel(input logic [3:0] src, input logic [7:0] t);
    logic v;
    v = 1'b1;
    if (src == SRC_FORCED) begin
      v = 1'b0;
    end else if (src >= 4'h1 && src <= 4'h8) begin
      v = t[3'(src - 4'h1)];
    end
    return v;
  endfunction : termLevel

  // address decode shared by read and write paths
  function automatic logic isMapped(input logic [7:0] a);
    return a == ADDR_PARAM || a == ADDR_ACTIVE || a == ADDR_PRESET1 || a == ADDR_PRESET2 ||
           a == ADDR_PRESET3 || a == ADDR_STATUS || a == ADDR_CONTROL;
  endfunction : isMapped

  // ****************************************************************
  // combinational next state
  // ****************************************************************
  logic [7:0]         terms;
  logic               clrSync;
  logic [2:0]         selSync;
  logic               pulseSync;
  logic               pulseNegSync;
  logic               sonLevel;
  logic               fwdLevel;
  logic               revLevel;
  logic               wrStrobe;
  logic               setup;
  logic signed [15:0] demand;
  logic signed [15:0] motorDemand;

  always_comb begin
    next_st = st;
    // only the second stage is read below
    next_st.sync1 = {cmdPulseNeg, cmdPulse, presetSpeedSelC, presetSpeedSelB,
                     presetSpeedSelA, errorCounterClear, inputTerms_n};
    next_st.sync2 = st.sync1;
    terms        = st.sync2[7:0];
    clrSync      = st.sync2[8];
    selSync      = st.sync2[11:9];
    pulseSync    = st.sync2[12];
    pulseNegSync = st.sync2[13];
    next_st.pulsePrev = pulseSync;
    next_st.encOut    = encPulseIn;

    // parameters copied into force once per startup
    if (!st.loaded) begin
      next_st.act    = st.pend;
      next_st.loaded = 1'b1;
    end

    sonLevel = termLevel(st.act.sonSrc, terms);
    fwdLevel = termLevel(st.act.fwdSrc, terms);
    revLevel = termLevel(st.act.revSrc, terms);
    next_st.energized = st.loaded && !sonLevel && !st.alarm;
    next_st.fwdBlock  = fwdLevel;
    next_st.revBlock  = revLevel;

    // position error: accumulates pulses, clear input wins
    if (clrSync) begin
      next_st.errCnt = '0;
    end else if (pulseSync && !st.pulsePrev && st.energized) begin
      next_st.errCnt = pulseNegSync ? st.errCnt - 16'sd1 : st.errCnt + 16'sd1;
    end

    // command source by mode
    case (st.act.mode)
      SVO_MODE_SPEED:  demand = speedRef;
      SVO_MODE_PULSE:  demand = st.errCnt;
      SVO_MODE_TORQUE: demand = torqueRef;
      SVO_MODE_PRESET: begin
        if (selSync[0]) begin
          demand = $signed(st.preset[0]);
        end else if (selSync[1]) begin
          demand = $signed(st.preset[1]);
        end else if (selSync[2]) begin
          demand = $signed(st.preset[2]);
        end else begin
          demand = '0;
        end
      end
      default:         demand = '0;
    endcase

    // limit test uses command sign, so it follows the direction setting
    if (!st.energized || (demand > 0 && st.fwdBlock) || (demand < 0 && st.revBlock)) begin
      motorDemand = '0;
    end else begin
      motorDemand = demand;
    end
    // positive is ccw when not reversed
    next_st.drive = st.act.dirRev ? -motorDemand : motorDemand;

    // alarm: set wins over clear; restart clears even with enable forced
    wrStrobe = apbReq.psel && apbReq.penable && apbReq.pwrite;
    if (alarmEvent) begin
      next_st.alarm = 1'b1;
    end else if (wrStrobe && apbReq.paddr == ADDR_CONTROL) begin
      if (apbReq.pwdata[CTL_RESTART]) begin
        next_st.alarm = 1'b0;
      end else if (apbReq.pwdata[CTL_ALMCLR] && st.act.sonSrc != SRC_FORCED) begin
        next_st.alarm = 1'b0;
      end
    end

    // register writes
    if (wrStrobe) begin
      case (apbReq.paddr)
        ADDR_PARAM: begin
          next_st.pend.dirRev = apbReq.pwdata[DIR_BIT];
          next_st.pend.mode   = svo_mode_e'(apbReq.pwdata[MODE_LSB +: 4]);
          next_st.pend.sonSrc = apbReq.pwdata[SON_LSB +: 4];
          next_st.pend.fwdSrc = apbReq.pwdata[FWD_LSB +: 4];
          next_st.pend.revSrc = apbReq.pwdata[REV_LSB +: 4];
        end
        ADDR_PRESET1: next_st.preset[0] = apbReq.pwdata[15:0];
        ADDR_PRESET2: next_st.preset[1] = apbReq.pwdata[15:0];
        ADDR_PRESET3: next_st.preset[2] = apbReq.pwdata[15:0];
        ADDR_CONTROL: begin
          if (apbReq.pwdata[CTL_RESTART]) begin
            next_st.loaded    = 1'b0;
            next_st.energized = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // read data captured in the setup cycle, answered with no wait
    setup = apbReq.psel && !apbReq.penable;
    if (setup) begin
      next_st.slverr = !isMapped(apbReq.paddr);
      case (apbReq.paddr)
        ADDR_PARAM:   next_st.rdata = {12'h0, st.pend.revSrc, st.pend.fwdSrc, st.pend.sonSrc,
                                       st.pend.mode, 3'h0, st.pend.dirRev};
        ADDR_ACTIVE:  next_st.rdata = {12'h0, st.act.revSrc, st.act.fwdSrc, st.act.sonSrc,
                                       st.act.mode, 3'h0, st.act.dirRev};
        ADDR_PRESET1: next_st.rdata = {16'h0, st.preset[0]};
        ADDR_PRESET2: next_st.rdata = {16'h0, st.preset[1]};
        ADDR_PRESET3: next_st.rdata = {16'h0, st.preset[2]};
        ADDR_STATUS:  next_st.rdata = {st.errCnt, 11'h0, st.loaded, st.alarm, st.revBlock,
                                       st.fwdBlock, st.energized};
        default:      next_st.rdata = 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // reset stands for a full power-up: stored parameters return to defaults
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.sync1     <= '1;
      st.sync2     <= '1;
      st.pend      <= svo_cfg_default(AXIS_B);
      st.act       <= svo_cfg_default(AXIS_B);
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign motorEnergized = st.energized;
  assign loopMode       = st.act.mode;
  assign driveCmd       = st.drive;
  assign encPulseOut    = st.encOut;
  assign alarm          = st.alarm;
  assign apbRsp.pready  = apbReq.psel && apbReq.penable;
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && st.slverr;
  assign apbRsp.prdata  = st.rdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_enable_high_off: assert property (st.sync2[3'(st.act.sonSrc - 4'h1)] && st.act.sonSrc >= 4'h1
      && st.act.sonSrc <= 4'h8 |=> !motorEnergized) else $error("motor on while enable high");
  a_enable_low_on: assert property (st.loaded && !st.alarm && st.act.sonSrc == SRC_FORCED
      ##1 st.loaded && !st.alarm |-> motorEnergized) else $error("forced enable not on");
  a_fwd_limit_stop: assert property (st.fwdBlock && !st.act.dirRev |-> driveCmd <= 0 || $past(!st.fwdBlock))
      else $error("positive drive past limit");
  a_rev_limit_stop: assert property (st.revBlock && !st.act.dirRev |-> driveCmd >= 0 || $past(!st.revBlock))
      else $error("negative drive past limit");
  a_clear_zeroes: assert property (st.sync2[8] |=> st.errCnt == 0) else $error("error count not cleared");
  a_alarm_clr_forced: assert property (st.alarm && st.act.sonSrc == SRC_FORCED && !(wrStrobe
      && apbReq.paddr == ADDR_CONTROL && apbReq.pwdata[CTL_RESTART]) |=> st.alarm)
      else $error("alarm cleared while enable forced");
  a_params_hold: assert property (st.loaded && $stable(st.loaded) |-> $stable(st.act))
      else $error("parameters changed without restart");
  a_sync_delay: assert property ($rose(errorCounterClear) ##1 errorCounterClear |=> st.sync2[8])
      else $error("clear synchroniser latency");
  a_direction_flip: assert property (st.act.dirRev && st.act.mode == SVO_MODE_SPEED && motorEnergized
      && !st.fwdBlock && !st.revBlock && $stable(speedRef) |=> driveCmd == -$past(speedRef))
      else $error("reversed drive wrong");
endmodule : svo_axis_ctrl

//--- svo_motion_partner.sv
// motion controller model: enable and limit terminals, selects, clear, pulses, refs
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/100ps
module svo_motion_partner (
  // clock
  input  wire logic          clock,
  // discrete lines toward the axis
  output logic [7:0]         terms_n,
  output logic               clr,
  output logic [2:0]         sel,
  output logic               pulse,
  output logic               pulseNeg,
  // analog command samples
  output logic signed [15:0] spd,
  output logic signed [15:0] trq,
  // drive-side events
  output logic               almEv,
  output logic               encIn
);
  // ****************************************************************
  // idle levels and commands
  // ****************************************************************
  // released switches read high, as a pull-up would leave them
  initial begin
    terms_n  = 8'hff;
    clr      = 1'b0;
    sel      = 3'h0;
    pulse    = 1'b0;
    pulseNeg = 1'b0;
    spd      = 16'h0000;
    trq      = 16'h0000;
    almEv    = 1'b0;
    encIn    = 1'b0;
  end
  // alarm source held two edges, then released
  task automatic pulseAlarm();
    almEv <= 1'b1;
    repeat (2) @(posedge clock);
    almEv <= 1'b0;
    @(posedge clock);
  endtask : pulseAlarm
  task automatic setEnc(input logic v);
    encIn <= v;
    @(posedge clock);
  endtask : setEnc
  // each task lets an edge pass so no line is driven twice in one step
  task automatic setTerms(input logic [7:0] v);
    terms_n <= v;
    @(posedge clock);
  endtask : setTerms
  task automatic setLines(input logic [2:0] s, input logic c);
    sel <= s;
    clr <= c;
    @(posedge clock);
  endtask : setLines
  // bench enables the servo before calling sendPulses; setRefs may come first
  task automatic setRefs(input logic [15:0] s, input logic [15:0] t);
    spd <= s;
    trq <= t;
    @(posedge clock);
  endtask : setRefs
  // two cycles high and low so the synchroniser sees every edge
  task automatic sendPulses(input int n, input logic neg);
    pulseNeg <= neg;
    repeat (2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      pulse <= 1'b1;
      repeat (2) @(posedge clock);
      pulse <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask : sendPulses
endmodule : svo_motion_partner

//--- svo_axis_ctrl_tb.sv
// self-checking bench for the servo axis control block
// assumes svo_pkg and svo_motion_partner are compiled first
`timescale 1ns/100ps
module svo_axis_ctrl_tb;
  import svo_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic               clock;
  logic               rst_n;
  svo_apb_req_s       apbReq;
  svo_apb_rsp_s       apbRsp;
  logic [7:0]         terms_n;
  logic               clr;
  logic [2:0]         sel;
  logic               pulse;
  logic               pulseNeg;
  logic signed [15:0] spd;
  logic signed [15:0] trq;
  logic               alarmEvent;
  logic               encPulseIn;
  logic               motorEnergized;
  svo_mode_e          loopMode;
  logic signed [15:0] driveCmd;
  logic               encPulseOut;
  logic               alarm;
  logic [31:0]        rd;
  logic               err;
  int                 fail_count;
  int                 check_count;
  logic [15:0]        presets [3] = '{16'h0011, 16'h0022, 16'h0033};

  svo_axis_ctrl uut (.clock(clock), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .inputTerms_n(terms_n), .errorCounterClear(clr), .presetSpeedSelA(sel[0]),
    .presetSpeedSelB(sel[1]), .presetSpeedSelC(sel[2]), .cmdPulse(pulse),
    .cmdPulseNeg(pulseNeg), .speedRef(spd), .torqueRef(trq), .alarmEvent(alarmEvent),
    .encPulseIn(encPulseIn), .motorEnergized(motorEnergized), .loopMode(loopMode),
    .driveCmd(driveCmd), .encPulseOut(encPulseOut), .alarm(alarm));
  svo_motion_partner partner (.clock(clock), .terms_n(terms_n), .clr(clr), .sel(sel),
    .pulse(pulse), .pulseNeg(pulseNeg), .spd(spd), .trq(trq), .almEv(alarmEvent),
    .encIn(encPulseIn));

  // ****************************************************************
  // tasks
  // ****************************************************************
  always #4 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  // one apb transfer; the request stands until pready is seen high or 20 edges have passed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    // let the release reach an edge before the next setup is driven
    @(posedge clock);
  endtask : apb
  // inputs need two sync stages plus gating; eight edges cover it
  task automatic settle();
    repeat (8) @(posedge clock);
  endtask : settle
  // stored value only takes force through the restart command
  task automatic restart(input logic [31:0] p);
    apb(1'b1, ADDR_PARAM, p);
    apb(1'b1, ADDR_CONTROL, 32'h00000001);
    settle();
  endtask : restart
  task automatic chkCmd(input logic [15:0] exp);
    chk("driveCmd", {16'h0000, exp}, {16'h0000, driveCmd});
  endtask : chkCmd
  task finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    finish_test();
  end
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    apbReq = '0;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, ADDR_PARAM, 32'h0);
    chk("PARAM", 32'h00043100, rd);
    apb(1'b0, ADDR_ACTIVE, 32'h0);
    chk("ACTIVE", 32'h00043100, rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    // terminal one released: motor stays off
    partner.setTerms(8'hf3);
    partner.setRefs(16'h0064, 16'h0123);
    settle();
    chk("energized off", 32'h0, {31'h0, motorEnergized});
    partner.setTerms(8'hf2);
    settle();
    chk("energized on", 32'h1, {31'h0, motorEnergized});
    chkCmd(16'h0064);
    partner.setTerms(8'hf6);
    settle();
    chkCmd(16'h0000);
    partner.setRefs(16'hff38, 16'h0123);
    settle();
    chkCmd(16'hff38);
    partner.setTerms(8'hfa);
    settle();
    chkCmd(16'h0000);
    partner.setTerms(8'hf2);
    apb(1'b1, ADDR_PARAM, 32'h00043120);
    settle();
    chk("mode held", 32'h0, {28'h0, loopMode});
    restart(32'h00043120);
    chk("mode torque", 32'h2, {28'h0, loopMode});
    chkCmd(16'h0123);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_PRESET1 + 8'(4 * i), {16'h0000, presets[i]});
    end
    restart(32'h00043130);
    for (int i = 0; i < 3; i++) begin
      partner.setLines(3'(1 << i), 1'b0);
      settle();
      chkCmd(presets[i]);
    end
    partner.setLines(3'h0, 1'b0);
    restart(32'h00043110);
    partner.sendPulses(5, 1'b0);
    settle();
    chkCmd(16'h0005);
    partner.sendPulses(2, 1'b1);
    settle();
    chkCmd(16'h0003);
    partner.setLines(3'h0, 1'b1);
    settle();
    partner.setLines(3'h0, 1'b0);
    chkCmd(16'h0000);
    restart(32'h00043101);
    partner.setRefs(16'h0064, 16'h0000);
    partner.setEnc(1'b1);
    settle();
    chkCmd(16'hff9c);
    chk("encoder out", 32'h1, {31'h0, encPulseOut});
    partner.setTerms(8'hf6);
    settle();
    chkCmd(16'h0000);
    partner.setRefs(16'hff9c, 16'h0000);
    settle();
    chkCmd(16'h0064);
    // forced enable and disabled positive limit with all terminals released
    partner.setTerms(8'hff);
    partner.setRefs(16'h0064, 16'h0000);
    restart(32'h00049900);
    chk("forced on", 32'h1, {31'h0, motorEnergized});
    chkCmd(16'h0064);
    partner.pulseAlarm();
    apb(1'b1, ADDR_CONTROL, 32'h00000002);
    settle();
    chk("alarm kept", 32'h1, {31'h0, alarm});
    apb(1'b1, ADDR_CONTROL, 32'h00000001);
    settle();
    chk("alarm cleared", 32'h0, {31'h0, alarm});
    finish_test();
  end
endmodule : svo_axis_ctrl_tb
